// [lpddr_cmd_power_state_logic.sv]
`timescale 1ns/10ps
`default_nettype none
`include "lpddr_defs.svh"

module lpddr_cmd_power_state_logic
   import lpddr_pkg::*;
(
   input  wire logic                   core_clk_in,
   input  wire logic                   reset_in,
   input  wire logic                   clk_en_in,
   input  wire pin_bus_t               pins_in,
   output logic                        beat_write_out,
   output logic [`DATA_W-1:0]          beat_data_out,
   output logic [`BANKS-1:0]           bank_open_out,
   output logic [`BANKS-1:0]           precharging_out,
   output logic                        refresh_busy_out,
   output logic [`REF_ADDR_W-1:0]      refresh_addr_out,
   output logic                        self_refresh_out,
   output logic                        power_down_out,
   output logic                        receivers_on_out,
   output logic                        internal_clk_on_out,
   output logic                        modes_ready_out
);

   pin_bus_t          pin_now;
   pin_bus_t          pin_prev;
   power_state_t      st_q;
   cmd_t              cmd;
   logic              ck_rise;
   logic              dqs_edge;
   logic              issue;
   logic              issue_rw;
   logic              cke_was_q;
   logic [2:0]        mode_q;
   logic [2:0]        ext_mode_q;
   logic              mode_set_q;
   logic              ext_set_q;
   beats_t            wr_left_q;
   logic [`BANK_W-1:0] wr_bank_q;
   logic              wr_ap_q;
   logic              wr_done;
   logic [`BANKS-1:0] rd_ap_q;
   logic [`BANKS-1:0] wr_rec_q;
   logic [`BANKS-1:0] ap_start;
   cnt_t              ras_cnt_q [`BANKS];
   cnt_t              twr_cnt_q [`BANKS];
   cnt_t              pre_cnt_q [`BANKS];
   beats_t            rd_edges_q [`BANKS];
   cnt_t              rfc_cnt_q;

   // burst length setting to beats per burst
   function automatic beats_t bl_beats(input logic [2:0] code);
      case (code)
         `BL_CODE_2: bl_beats = `BEATS_2;
         `BL_CODE_4: bl_beats = `BEATS_4;
         `BL_CODE_8: bl_beats = `BEATS_8;
         default:    bl_beats = `BEATS_4;
      endcase
   endfunction : bl_beats

   // command decode at a clock rising edge
   function automatic cmd_t decode_cmd(input pin_bus_t p, input logic cke_was);
      decode_cmd = CMD_NOP;
      if (cke_was && !p.cs_n) begin
         case ({p.ras_n, p.cas_n, p.we_n})
            `CODE_ACT:   decode_cmd = CMD_ACT;
            `CODE_READ:  decode_cmd = CMD_READ;
            `CODE_WRITE: decode_cmd = CMD_WRITE;
            `CODE_PRE:   decode_cmd = CMD_PRE;
            `CODE_REF:   decode_cmd = p.cke ? CMD_REF : CMD_SREF;
            `CODE_MODE:  decode_cmd = CMD_MODE;
            default:     decode_cmd = CMD_NOP;
         endcase
      end
   endfunction : decode_cmd

   pin_sync u_sync (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .clk_en_in   (clk_en_in),
      .pins_in     (pins_in),
      .now_out     (pin_now),
      .prev_out    (pin_prev)
   );

   // edges of the sampled link clock and strobe
   assign ck_rise  = pin_now.ck & ~pin_prev.ck;
   assign dqs_edge = pin_now.dqs ^ pin_prev.dqs;
   assign cmd      = decode_cmd(pin_now, cke_was_q);
   assign issue    = ck_rise && (st_q == ST_AWAKE);
   assign issue_rw = issue && modes_ready_out;
   assign wr_done  = dqs_edge && (wr_left_q == 4'h1) && wr_ap_q;

   // clock enable as seen at the previous clock edge
   always_ff @(posedge core_clk_in) begin
      if (reset_in)
         cke_was_q <= 1'b0;
      else if (clk_en_in && ck_rise)
         cke_was_q <= pin_now.cke;
   end

   // power state: self refresh, power down, awake
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         st_q                <= ST_AWAKE;
         receivers_on_out    <= 1'b1;
         internal_clk_on_out <= 1'b1;
         self_refresh_out    <= 1'b0;
         power_down_out      <= 1'b0;
      end else if (clk_en_in) begin
         case (st_q)
            ST_AWAKE: begin
               if (ck_rise && cke_was_q && !pin_now.cke) begin
                  receivers_on_out <= 1'b0;
                  if (cmd == CMD_SREF) begin
                     st_q                <= ST_SELF_REFRESH;
                     internal_clk_on_out <= 1'b0;
                     self_refresh_out    <= 1'b1;
                  end else begin
                     st_q           <= ST_POWER_DOWN;
                     power_down_out <= 1'b1;
                  end
               end
            end
            ST_SELF_REFRESH, ST_POWER_DOWN: begin
               if (pin_now.cke) begin
                  st_q                <= ST_AWAKE;
                  receivers_on_out    <= 1'b1;
                  internal_clk_on_out <= 1'b1;
                  self_refresh_out    <= 1'b0;
                  power_down_out      <= 1'b0;
               end
            end
            default: st_q <= ST_AWAKE;
         endcase
      end
   end

   // mode registers keep no reset value, only their programmed flags
   always_ff @(posedge core_clk_in) begin
      if (clk_en_in && issue && cmd == CMD_MODE) begin
         if (pin_now.bank == `MODE_BANK)
            mode_q <= pin_now.addr_low;
         if (pin_now.bank == `EXT_MODE_BANK)
            ext_mode_q <= pin_now.addr_low;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         mode_set_q      <= 1'b0;
         ext_set_q       <= 1'b0;
         modes_ready_out <= 1'b0;
      end else if (clk_en_in) begin
         if (issue && cmd == CMD_MODE && pin_now.bank == `MODE_BANK)
            mode_set_q <= 1'b1;
         if (issue && cmd == CMD_MODE && pin_now.bank == `EXT_MODE_BANK)
            ext_set_q <= 1'b1;
         modes_ready_out <= mode_set_q && ext_set_q;
      end
   end

   // write burst: beats counted on strobe edges, masked ones dropped
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         wr_left_q      <= '0;
         wr_bank_q      <= '0;
         wr_ap_q        <= 1'b0;
         beat_write_out <= 1'b0;
         beat_data_out  <= '0;
      end else if (clk_en_in) begin
         beat_write_out <= 1'b0;
         if (issue_rw && cmd == CMD_WRITE) begin
            wr_left_q <= bl_beats(mode_q);
            wr_bank_q <= pin_now.bank;
            wr_ap_q   <= pin_now.auto_precharge_select;
         end else if (dqs_edge && wr_left_q != '0) begin
            wr_left_q <= wr_left_q - 4'h1;
            if (!pin_now.write_byte_mask) begin
               beat_write_out <= 1'b1;
               beat_data_out  <= pin_now.data;
            end
         end
      end
   end

   // auto-precharge start: read after half a burst, write after recovery
   always_comb begin
      for (int b = 0; b < `BANKS; b++) begin
         ap_start[b] = (ras_cnt_q[b] == '0) &&
                       ((rd_ap_q[b] && rd_edges_q[b] == '0) ||
                        (wr_rec_q[b] && twr_cnt_q[b] == '0));
      end
   end

   // per-bank row, auto-precharge and precharge timing
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         bank_open_out   <= '0;
         precharging_out <= '0;
         rd_ap_q         <= '0;
         wr_rec_q        <= '0;
         for (int b = 0; b < `BANKS; b++) begin
            ras_cnt_q[b]  <= '0;
            twr_cnt_q[b]  <= '0;
            pre_cnt_q[b]  <= '0;
            rd_edges_q[b] <= '0;
         end
      end else if (clk_en_in) begin
         for (int b = 0; b < `BANKS; b++) begin
            if (ras_cnt_q[b] != '0)
               ras_cnt_q[b] <= ras_cnt_q[b] - cnt_t'(1);
            if (twr_cnt_q[b] != '0)
               twr_cnt_q[b] <= twr_cnt_q[b] - cnt_t'(1);
            if (ck_rise && rd_edges_q[b] != '0)
               rd_edges_q[b] <= rd_edges_q[b] - 4'h1;
            if (pre_cnt_q[b] != '0)
               pre_cnt_q[b] <= pre_cnt_q[b] - cnt_t'(1);
            if (pre_cnt_q[b] <= cnt_t'(1))
               precharging_out[b] <= 1'b0;
            if (issue_rw && cmd == CMD_ACT && pin_now.bank == b) begin
               bank_open_out[b] <= 1'b1;
               ras_cnt_q[b]     <= cnt_t'(`MIN_ACTIVATE_TO_PRECHARGE_CYC);
            end
            if (issue_rw && cmd == CMD_READ && pin_now.bank == b &&
                pin_now.auto_precharge_select) begin
               rd_ap_q[b]    <= 1'b1;
               rd_edges_q[b] <= bl_beats(mode_q) >> 1;
            end
            if (wr_done && wr_bank_q == b) begin
               wr_rec_q[b]  <= 1'b1;
               twr_cnt_q[b] <= cnt_t'(`TWR_CYC);
            end
            if (ap_start[b] || (issue && cmd == CMD_PRE &&
                (pin_now.auto_precharge_select || pin_now.bank == b))) begin
               bank_open_out[b]   <= 1'b0;
               rd_ap_q[b]         <= 1'b0;
               wr_rec_q[b]        <= 1'b0;
               precharging_out[b] <= 1'b1;
               pre_cnt_q[b]       <= cnt_t'(`TRP_CYC);
            end
            if (issue && cmd == CMD_REF) begin
               bank_open_out[b] <= 1'b0;
               rd_ap_q[b]       <= 1'b0;
               wr_rec_q[b]      <= 1'b0;
            end
         end
      end
   end

   // refresh address counter and refresh cycle busy
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         rfc_cnt_q        <= '0;
         refresh_busy_out <= 1'b0;
         refresh_addr_out <= '0;
      end else if (clk_en_in) begin
         if (issue && (cmd == CMD_REF || cmd == CMD_SREF))
            refresh_addr_out <= refresh_addr_out + 1'b1;
         if (issue && cmd == CMD_REF) begin
            rfc_cnt_q        <= cnt_t'(`REFRESH_CYCLE_TIME_CYC);
            refresh_busy_out <= 1'b1;
         end else begin
            if (rfc_cnt_q != '0)
               rfc_cnt_q <= rfc_cnt_q - cnt_t'(1);
            if (rfc_cnt_q <= cnt_t'(1))
               refresh_busy_out <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in || !clk_en_in);

   sequence s_masked_beat;
      dqs_edge && wr_left_q != '0 && pin_now.write_byte_mask;
   endsequence
   sequence s_clean_beat;
      dqs_edge && wr_left_q != '0 && !pin_now.write_byte_mask && !issue_rw;
   endsequence
   sequence s_act0;
      issue_rw && cmd == CMD_ACT && pin_now.bank == '0;
   endsequence

   chk_mask_drop:   assert property (s_masked_beat |=> !beat_write_out)
      else $error("masked beat was written");
   chk_beat_data:   assert property (s_clean_beat |=> beat_write_out &&
                                     beat_data_out == $past(pin_now.data))
      else $error("unmasked beat lost or corrupted");
   chk_ap_select:   assert property (issue_rw && cmd == CMD_WRITE &&
                                     !pin_now.auto_precharge_select |=> !wr_ap_q)
      else $error("write without select armed auto-precharge");
   chk_ras_wait:    assert property (s_act0 |=> !ap_start[0] [*8])
      else $error("auto-precharge before activate minimum");
   chk_wr_recovery: assert property (wr_done |=>
                                     !ap_start[wr_bank_q] [*3])
      else $error("write auto-precharge before recovery");
   chk_refresh_idle: assert property (issue && cmd == CMD_REF |=>
                                      bank_open_out == '0 && refresh_busy_out)
      else $error("banks open after refresh");
   chk_sref_hold:   assert property (st_q == ST_SELF_REFRESH && !pin_now.cke |=>
                                     self_refresh_out && !internal_clk_on_out)
      else $error("left self refresh with enable low");
   chk_pdn_gate:    assert property (st_q == ST_POWER_DOWN |->
                                     !receivers_on_out && power_down_out)
      else $error("receivers on in power down");
   chk_mode_gate:   assert property (!modes_ready_out && issue &&
                                     cmd == CMD_WRITE |=> wr_left_q == '0)
      else $error("write accepted before modes programmed");

endmodule : lpddr_cmd_power_state_logic

`default_nettype wire

// [lpddr_defs.svh]
`ifndef LPDDR_DEFS_SVH
`define LPDDR_DEFS_SVH

// core clock period and time-to-cycle conversion, least times round up
`define CLK_PERIOD_PS     5000
`define NS_TO_CYC(ns)     ((((ns) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// array timing, figures in ns
`define MIN_ACTIVATE_TO_PRECHARGE_NS           42
`define TWR_NS            15
`define TRP_NS            18
`define REFRESH_CYCLE_TIME_NS           72
`define MIN_ACTIVATE_TO_PRECHARGE_CYC          `NS_TO_CYC(`MIN_ACTIVATE_TO_PRECHARGE_NS)
`define TWR_CYC           `NS_TO_CYC(`TWR_NS)
`define TRP_CYC           `NS_TO_CYC(`TRP_NS)
`define REFRESH_CYCLE_TIME_CYC          `NS_TO_CYC(`REFRESH_CYCLE_TIME_NS)

// geometry
`define BANKS             4
`define BANK_W            2
`define DATA_W            8
`define CNT_W             6
`define REF_ADDR_W        12

// command pin codes {ras_n, cas_n, we_n}
`define CODE_ACT          3'h3
`define CODE_READ         3'h5
`define CODE_WRITE        3'h4
`define CODE_PRE          3'h2
`define CODE_REF          3'h1
`define CODE_MODE         3'h0

// mode register fields and bank selects for mode programming
`define BL_CODE_2         3'h1
`define BL_CODE_4         3'h2
`define BL_CODE_8         3'h3
`define BEATS_2           4'h2
`define BEATS_4           4'h4
`define BEATS_8           4'h8
`define MODE_BANK         2'h0
`define EXT_MODE_BANK     2'h2

`endif

// [lpddr_pkg.sv]
`default_nettype none
package lpddr_pkg;
`include "lpddr_defs.svh"

   // pin group as seen at the die
   typedef struct packed {
      logic                ck;
      logic                cke;
      logic                cs_n;
      logic                ras_n;
      logic                cas_n;
      logic                we_n;
      logic                auto_precharge_select;
      logic [`BANK_W-1:0]  bank;
      logic [2:0]          addr_low;
      logic                dqs;
      logic                write_byte_mask;
      logic [`DATA_W-1:0]  data;
   } pin_bus_t;

   typedef enum {ST_AWAKE, ST_SELF_REFRESH, ST_POWER_DOWN} power_state_t;

   typedef enum {CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE,
                 CMD_REF, CMD_SREF, CMD_MODE} cmd_t;

   typedef logic [`CNT_W-1:0] cnt_t;
   typedef logic [3:0]        beats_t;

endpackage : lpddr_pkg
`default_nettype wire

// [pin_sync.sv]
`timescale 1ns/10ps
`default_nettype none

module pin_sync
   import lpddr_pkg::*;
(
   input  wire logic     core_clk_in,
   input  wire logic     reset_in,
   input  wire logic     clk_en_in,
   input  wire pin_bus_t pins_in,
   output pin_bus_t      now_out,
   output pin_bus_t      prev_out
);

   pin_bus_t meta_q;

   // two-flop synchroniser plus one stage for edge finding
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         meta_q   <= '0;
         now_out  <= '0;
         prev_out <= '0;
      end else if (clk_en_in) begin
         meta_q   <= pins_in;
         now_out  <= meta_q;
         prev_out <= now_out;
      end
   end

endmodule : pin_sync

`default_nettype wire

// [host_ctrl_model.sv]
`timescale 1ns/10ps
`default_nettype none
`include "lpddr_defs.svh"

module host_ctrl_model
   import lpddr_pkg::*;
#(
   parameter int POWERUP_NS = 200000
)
(
   input  wire logic    core_clk_in,
   output var pin_bus_t pins_out
);

   // idle pins: clock parked low, deselected, enable high
   initial begin
      pins_out = '0;
      pins_out.cke = 1'b1;
      pins_out.cs_n = 1'b1;
   end

   // one link clock cycle carrying one command
   task automatic issue(input logic cke, input logic sel,
                        input logic [2:0] code, input logic ap,
                        input logic [1:0] bank, input logic [2:0] low);
      @(negedge core_clk_in);
      pins_out.cke = cke;
      pins_out.cs_n = ~sel;
      {pins_out.ras_n, pins_out.cas_n, pins_out.we_n} = code;
      pins_out.auto_precharge_select = ap;
      pins_out.bank = bank;
      pins_out.addr_low = low;
      repeat (6) @(negedge core_clk_in);
      pins_out.ck = 1'b1;
      repeat (6) @(negedge core_clk_in);
      // high six cycles, low seven: nearest to 64 ns on falling edges
      // clock parks low when idle, enable untouched
      pins_out.ck = 1'b0;
      pins_out.cs_n = 1'b1;
      {pins_out.ras_n, pins_out.cas_n, pins_out.we_n} = ~code;
      pins_out.auto_precharge_select = ~ap;
      pins_out.bank = ~bank;
      pins_out.addr_low = ~low;
   endtask : issue

   // deselect cycle with a running clock
   task automatic nop(input logic cke);
      issue(cke, 1'b0, 3'h7, 1'b0, 2'h0, 3'h0);
   endtask : nop

   // stable clock and no-operation before initialising
   task automatic powerup();
      repeat (POWERUP_NS / 64) nop(1'b1);
   endtask : powerup

   task automatic set_cke(input logic v);
      @(negedge core_clk_in);
      pins_out.cke = v;
   endtask : set_cke

   // four beats, mask travels with its strobe edge
   task automatic write_beats(input logic [31:0] d, input logic [3:0] m);
      for (int i = 0; i < 4; i++) begin
         @(negedge core_clk_in);
         pins_out.data = d[8*i +: 8];
         pins_out.write_byte_mask = m[i];
         pins_out.dqs = ~pins_out.dqs;
         repeat (2) @(negedge core_clk_in);
      end
      @(negedge core_clk_in);
      pins_out.data = ~pins_out.data; // released data flips
   endtask : write_beats

endmodule : host_ctrl_model
`default_nettype wire

// [lpddr_cmd_power_state_logic_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "lpddr_defs.svh"

module lpddr_cmd_power_state_logic_tb_top
   import lpddr_pkg::*;
;
   logic                   core_clk_in;
   logic                   reset_in;
   logic                   clk_en_in;
   pin_bus_t               pins;
   logic                   beat_write_out;
   logic [`DATA_W-1:0]     beat_data_out;
   logic [`BANKS-1:0]      bank_open_out;
   logic [`BANKS-1:0]      precharging_out;
   logic                   refresh_busy_out;
   logic [`REF_ADDR_W-1:0] refresh_addr_out;
   logic                   self_refresh_out;
   logic                   power_down_out;
   logic                   receivers_on_out;
   logic                   internal_clk_on_out;
   logic                   modes_ready_out;
   int                     miscompares;
   int                     cmp_count;
   int                     beats;
   logic [31:0]            got;
   logic [3:0]             pre_seen;

   lpddr_cmd_power_state_logic u_lpddr_cmd_power_state_logic (
      .core_clk_in(core_clk_in), .reset_in(reset_in),
      .clk_en_in(clk_en_in), .pins_in(pins),
      .beat_write_out(beat_write_out), .beat_data_out(beat_data_out),
      .bank_open_out(bank_open_out), .precharging_out(precharging_out),
      .refresh_busy_out(refresh_busy_out),
      .refresh_addr_out(refresh_addr_out),
      .self_refresh_out(self_refresh_out), .power_down_out(power_down_out),
      .receivers_on_out(receivers_on_out),
      .internal_clk_on_out(internal_clk_on_out),
      .modes_ready_out(modes_ready_out));

   host_ctrl_model u_host_ctrl_model (
      .core_clk_in(core_clk_in), .pins_out(pins));

   initial begin
      core_clk_in = 1'b0;
      forever #2.5 core_clk_in = ~core_clk_in;
   end

   // count accepted beats and latch any precharge seen
   always @(posedge core_clk_in) begin
      if (beat_write_out === 1'b1) begin
         beats <= beats + 1;
         got <= {got[23:0], beat_data_out};
      end
      pre_seen <= pre_seen | precharging_out;
   end

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic cmd(input logic [2:0] code, input logic ap,
                      input logic [1:0] bank, input logic [2:0] low);
      u_host_ctrl_model.issue(1'b1, 1'b1, code, ap, bank, low);
   endtask : cmd

   task automatic clear_obs();
      @(negedge core_clk_in);
      beats = 0;
      pre_seen = '0;
   endtask : clear_obs

   task automatic t_reset();
      check("modes_ready", modes_ready_out, 0);
      check("rst_state", {bank_open_out, precharging_out, refresh_busy_out,
            self_refresh_out, power_down_out, receivers_on_out,
            internal_clk_on_out}, 13'h0003);
      $display("test reset done");
   endtask : t_reset

   task automatic t_init();
      u_host_ctrl_model.powerup();
      cmd(`CODE_ACT, 1'b0, 2'h0, 3'h0);
      check("act_unprogrammed", bank_open_out, 0);
      cmd(`CODE_WRITE, 1'b1, 2'h0, 3'h0);
      u_host_ctrl_model.write_beats(32'h5a5a5a5a, 4'h0);
      check("write_unprogrammed", beats, 0);
      cmd(`CODE_PRE, 1'b1, 2'h0, 3'h0);
      u_host_ctrl_model.nop(1'b1);
      for (int i = 1; i <= 2; i++) begin
         cmd(`CODE_REF, 1'b0, 2'h0, 3'h0);
         check("refresh_busy", refresh_busy_out, 1);
         check("refresh_addr", refresh_addr_out, i);
         check("banks_idle", bank_open_out, 0);
         repeat (2) u_host_ctrl_model.nop(1'b1);
      end
      cmd(`CODE_MODE, 1'b0, `MODE_BANK, `BL_CODE_4);
      check("ready_after_mode", modes_ready_out, 0);
      cmd(`CODE_MODE, 1'b0, `EXT_MODE_BANK, 3'h0);
      check("ready_after_ext", modes_ready_out, 1);
      $display("test init done");
   endtask : t_init

   task automatic t_write_ap();
      cmd(`CODE_ACT, 1'b0, 2'h1, 3'h0);
      check("open_b1", bank_open_out, 4'h2);
      clear_obs();
      cmd(`CODE_WRITE, 1'b1, 2'h1, 3'h0);
      u_host_ctrl_model.write_beats(32'h44332211, 4'b0010);
      check("pre_early", pre_seen, 0);
      repeat (12) @(negedge core_clk_in);
      check("beat_count", beats, 3);
      check("beat_data", got[23:0], 24'h113344);
      check("pre_b1", pre_seen, 4'h2);
      check("closed_b1", bank_open_out, 0);
      $display("test write auto precharge done");
   endtask : t_write_ap

   task automatic t_write_plain();
      cmd(`CODE_ACT, 1'b0, 2'h3, 3'h0);
      clear_obs();
      cmd(`CODE_WRITE, 1'b0, 2'h3, 3'h0);
      u_host_ctrl_model.write_beats(32'h8899aabb, 4'hf);
      repeat (12) @(negedge core_clk_in);
      check("masked_beats", beats, 0);
      check("no_pre_b3", pre_seen, 0);
      check("open_b3", bank_open_out, 4'h8);
      cmd(`CODE_PRE, 1'b0, 2'h3, 3'h0);
      u_host_ctrl_model.nop(1'b1);
      $display("test write plain done");
   endtask : t_write_plain

   task automatic t_read_ap();
      cmd(`CODE_ACT, 1'b0, 2'h0, 3'h0);
      cmd(`CODE_ACT, 1'b0, 2'h2, 3'h0);
      clear_obs();
      cmd(`CODE_READ, 1'b0, 2'h0, 3'h0);
      cmd(`CODE_READ, 1'b1, 2'h2, 3'h0);
      check("open_after_read", bank_open_out, 4'h5);
      u_host_ctrl_model.nop(1'b1);
      check("pre_one_rise", pre_seen, 0);
      u_host_ctrl_model.nop(1'b1);
      check("pre_two_rises", pre_seen, 4'h4);
      check("open_b0_only", bank_open_out, 4'h1);
      u_host_ctrl_model.nop(1'b1);
      cmd(`CODE_PRE, 1'b1, 2'h0, 3'h0);
      u_host_ctrl_model.nop(1'b1);
      $display("test read auto precharge done");
   endtask : t_read_ap

   task automatic t_self_refresh();
      u_host_ctrl_model.issue(1'b0, 1'b1, `CODE_REF, 1'b0, 2'h0, 3'h0);
      check("sref_in", {self_refresh_out, internal_clk_on_out,
            receivers_on_out}, 3'b100);
      check("sref_addr", refresh_addr_out, 3);
      repeat (20) @(negedge core_clk_in);
      u_host_ctrl_model.nop(1'b0);
      u_host_ctrl_model.set_cke(1'b1);
      repeat (5) @(negedge core_clk_in);
      check("sref_out", {self_refresh_out, internal_clk_on_out,
            receivers_on_out}, 3'b011);
      u_host_ctrl_model.nop(1'b1);
      $display("test self refresh done");
   endtask : t_self_refresh

   task automatic t_power_down();
      u_host_ctrl_model.nop(1'b0);
      check("pd_in", {power_down_out, receivers_on_out,
            internal_clk_on_out}, 3'b101);
      u_host_ctrl_model.issue(1'b0, 1'b1, `CODE_ACT, 1'b0, 2'h0, 3'h0);
      check("pd_gated", bank_open_out, 0);
      u_host_ctrl_model.set_cke(1'b1);
      repeat (5) @(negedge core_clk_in);
      check("pd_out", {power_down_out, receivers_on_out,
            internal_clk_on_out}, 3'b011);
      u_host_ctrl_model.nop(1'b1);
      cmd(`CODE_ACT, 1'b0, 2'h0, 3'h0);
      check("act_after_pd", bank_open_out, 4'h1);
      cmd(`CODE_PRE, 1'b1, 2'h0, 3'h0);
      $display("test power down done");
   endtask : t_power_down

   // clock enable low freezes state; mid-run reset clears it
   task automatic t_freeze_reset();
      cmd(`CODE_ACT, 1'b0, 2'h0, 3'h0);
      @(negedge core_clk_in);
      clk_en_in = 1'b0;
      cmd(`CODE_PRE, 1'b1, 2'h0, 3'h0);
      check("frozen_open", bank_open_out, 4'h1);
      @(negedge core_clk_in);
      clk_en_in = 1'b1;
      cmd(`CODE_PRE, 1'b1, 2'h0, 3'h0);
      check("pre_all", bank_open_out, 0);
      @(negedge core_clk_in);
      reset_in = 1'b1;
      repeat (2) @(negedge core_clk_in);
      reset_in = 1'b0;
      @(negedge core_clk_in);
      check("rst_again", {bank_open_out, precharging_out, refresh_busy_out,
            self_refresh_out, power_down_out, receivers_on_out,
            internal_clk_on_out}, 13'h0003);
      check("modes_lost", modes_ready_out, 0);
      u_host_ctrl_model.nop(1'b1);
      cmd(`CODE_ACT, 1'b0, 2'h1, 3'h0);
      check("act_after_rst", bank_open_out, 0);
      $display("test freeze and reset done");
   endtask : t_freeze_reset

   // main sequence
   initial begin
      reset_in = 1'b1;
      clk_en_in = 1'b1;
      miscompares = 0;
      cmp_count = 0;
      beats = 0;
      got = '0;
      pre_seen = '0;
      repeat (2) @(negedge core_clk_in);
      reset_in = 1'b0;
      @(negedge core_clk_in);
      t_reset();
      t_init();
      t_write_ap();
      t_write_plain();
      t_read_ap();
      t_self_refresh();
      t_power_down();
      t_freeze_reset();
      tally_and_finish();
   end

   // hang guard
   initial begin
      #400000;
      miscompares++;
      tally_and_finish();
   end

endmodule : lpddr_cmd_power_state_logic_tb_top
`default_nettype wire
